// ---- design/dlcr_map.vh ----
// register offsets, field positions, reset values and timing counts
`ifndef DLCR_MAP_VH
`define DLCR_MAP_VH
// register offsets (index on the register-access path)
`define DLCR_OFS_REV      4'h0
`define DLCR_OFS_ERR      4'h1
`define DLCR_OFS_TIMING   4'h2
`define DLCR_OFS_FEATURE  4'h3
`define DLCR_OFS_KEYS     4'h7
`define DLCR_OFS_SYSRST   4'h8
`define DLCR_OFS_CLKSEL   4'h9
`define DLCR_OFS_SYSCTL   4'ha
`define DLCR_OFS_SYSSTAT  4'hb
`define DLCR_OFS_CRCSTAT  4'hc
// interface revision, value arbitrary
`define DLCR_REVISION     4'h3
// link_timing_control fields
`define DLCR_GAPEN_BIT    7
`define DLCR_PAROFF_BIT   5
`define DLCR_TOOFF_BIT    4
`define DLCR_SIGOFF_BIT   3
`define DLCR_GT_MSB       2
// link_feature_control fields
`define DLCR_NACKOFF_BIT  4
`define DLCR_CCDIS_BIT    3
`define DLCR_IFDIS_BIT    2
// key_flags fields
`define DLCR_UROW_BIT     5
`define DLCR_NVM_BIT      4
`define DLCR_ERASE_BIT    3
// system_control fields
`define DLCR_UROWDONE_BIT 1
`define DLCR_CLKREQ_BIT   0
// reset values
`define DLCR_TIMING_RST   8'h00
`define DLCR_FEATURE_RST  8'h00
`define DLCR_KEYS_RST     3'h0
`define DLCR_SYSRST_RST   8'h00
`define DLCR_CLKSEL_RST   2'h3
`define DLCR_SYSCTL_RST   2'h0
// reset request words
`define DLCR_RST_ASSERT   8'h59
`define DLCR_RST_RELEASE  8'h00
// error signatures
`define DLCR_SIG_NONE     3'h0
`define DLCR_SIG_PARITY   3'h1
`define DLCR_SIG_FRAME    3'h2
`define DLCR_SIG_TIMEOUT  3'h3
`define DLCR_SIG_START    3'h4
`define DLCR_SIG_BUS      3'h6
`define DLCR_SIG_CONTEND  3'h7
// timing counts in link clock cycles / bit times
`define DLCR_TIMEOUT_CYC  17'h1_0000
`define DLCR_GAP_BITS     8'h02
`define DLCR_GUARD_MAX    8'h80
`endif

// ---- design/dlcr_timer.v ----
// down-counting one-shot timer driven by a tick enable
`timescale 1ns/10ps
module dlcr_timer #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // control
  input wire i_start,
  input wire i_stop,
  input wire i_tick,
  input wire [WIDTH-1:0] i_load,
  // status
  output reg o_busy,
  output reg o_expire
);
  reg [WIDTH-1:0] cnt_q; // ticks still to wait

  // ----------------------------------------
  // count loaded ticks, pulse on the last
  // ----------------------------------------
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_q <= {WIDTH{1'b0}};
      o_busy <= 1'b0;
      o_expire <= 1'b0;
    end
    else
    begin
      o_expire <= 1'b0;
      if (i_stop)
      begin
        // stop beats a start in the same cycle
        o_busy <= 1'b0;
      end
      else if (i_start)
      begin
        cnt_q <= i_load;
        o_busy <= 1'b1;
      end
      else if (o_busy && i_tick)
      begin
        if (cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1})
        begin
          o_busy <= 1'b0;
          o_expire <= 1'b1;
        end
        cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // dlcr_timer

// ---- design/dlcr_regs.v ----
// control and status registers of the single-wire debug link
//
// Summary of operation
// RULE1: registers reachable only via link access port
// RULE2: read-only revision in upper status nibble
// RULE3: error signature loaded on error, read-clears
// RULE4: parity error 0x1, no error 0x0
// RULE5: stop bit error gives 0x2
// RULE6: access-layer time-out gives 0x3
// RULE7: start bit error 0x4, 0x5 unused
// RULE8: bus error 0x6, contention 0x7
// RULE9: two idle bits between load bytes
// RULE10: parity disable ignores parity errors
// RULE11: response required within 65536 link cycles
// RULE12: response signature disable stops signatures
// RULE13: guard time from three-bit code
// RULE14: nack disable suppresses reset nack
// RULE15: contention detection unless disable bit set
// RULE16: interface disable clears config and keys
// RULE17: user-row flag set on key, write clears
// RULE18: nvm flag set on key, cleared on start
// RULE19: erase flag cleared by erase reset request
// RULE20: 0x59 asserts system reset, 0x00 releases
// RULE21: two-bit link clock select, default 0x3
// RULE22: reserved offsets read zero, writes ignored
`timescale 1ns/10ps
`include "dlcr_map.vh"
module dlcr_regs #(
  // response time-out in link cycles, shorten for simulation
  parameter [16:0] TIMEOUT_CYC = `DLCR_TIMEOUT_CYC
) (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // register access from link instruction decoder
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [3:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata,
  output reg o_reg_rvalid,
  // link physical layer events
  input wire i_parity_err,
  input wire i_frame_err,
  input wire i_start_err,
  input wire i_bus_err,
  input wire i_contention,
  input wire i_bit_tick,
  input wire i_turnaround,
  input wire i_byte_sent,
  input wire i_ld_multi,
  // access layer handshake
  input wire i_layer_wait,
  input wire i_layer_resp,
  // key decoder and system side
  input wire i_key_urow,
  input wire i_key_nvm,
  input wire i_key_erase,
  input wire i_nvm_started,
  input wire i_sys_reset_seen,
  input wire i_ldst_busy,
  input wire [7:0] i_sys_state,
  input wire [2:0] i_crc_state,
  // link layer configuration
  output reg o_parity_check_en,
  output reg o_resp_sig_en,
  output reg o_contention_det_en,
  output reg [1:0] o_link_clk_sel,
  // link layer timing
  output wire o_guard_busy,
  output wire o_gap_busy,
  output reg o_timeout,
  output reg o_send_nack,
  // system side
  output reg o_sys_reset_req,
  output reg o_sys_clk_req,
  output reg o_urow_done,
  output reg o_iface_reset
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [7:0] timing_q; // link_timing_control
  reg [2:0] feature_q; // link_feature_control bits 4:2
  reg [2:0] err_sig_q; // error signature
  reg [2:0] keys_q; // urow, nvm, erase flags
  reg [7:0] sysrst_q; // system_reset_request word
  // full-byte reset value, only bits 4:2 are stored
  localparam [7:0] FEATURE_RST = `DLCR_FEATURE_RST;
  reg [1:0] clksel_q; // link clock select
  reg [1:0] sysctl_q; // system_control bits
  reg [2:0] err_sig_d;
  reg err_hit;
  reg [7:0] rdata_d;
  reg [7:0] guard_load;
  wire timeout_hit;
  wire wr_timing;
  wire wr_feature;
  wire wr_keys;
  wire wr_sysrst;
  wire wr_clksel;
  wire wr_sysctl;
  wire rd_err;
  wire disable_now;

  // address strobes, only the link access port reaches them
  // RULE1: link port only
  assign wr_timing = i_reg_wr && (i_reg_addr == `DLCR_OFS_TIMING);
  assign wr_feature = i_reg_wr && (i_reg_addr == `DLCR_OFS_FEATURE);
  assign wr_keys = i_reg_wr && (i_reg_addr == `DLCR_OFS_KEYS);
  assign wr_sysrst = i_reg_wr && (i_reg_addr == `DLCR_OFS_SYSRST);
  assign wr_clksel = i_reg_wr && (i_reg_addr == `DLCR_OFS_CLKSEL);
  assign wr_sysctl = i_reg_wr && (i_reg_addr == `DLCR_OFS_SYSCTL);
  assign rd_err = i_reg_rd && (i_reg_addr == `DLCR_OFS_ERR);
  // RULE16: disable request
  assign disable_now = wr_feature && i_reg_wdata[`DLCR_IFDIS_BIT];

  // ----------------------------------------
  // error signature selection
  // ----------------------------------------
  // one code fits at a time, the most severe event is kept
  always @*
  begin
    err_hit = 1'b1;
    err_sig_d = `DLCR_SIG_NONE;
    // RULE15: contention gated
    if (i_contention && !feature_q[1])
      // RULE8: contention code
      err_sig_d = `DLCR_SIG_CONTEND;
    else if (i_bus_err)
      // RULE8: bus error code
      err_sig_d = `DLCR_SIG_BUS;
    else if (i_start_err)
      // RULE7: start bit code
      err_sig_d = `DLCR_SIG_START;
    else if (timeout_hit)
      // RULE6: time-out code
      err_sig_d = `DLCR_SIG_TIMEOUT;
    else if (i_frame_err)
      // RULE5: stop bit code
      err_sig_d = `DLCR_SIG_FRAME;
    // RULE10: parity ignored when disabled
    else if (i_parity_err && !timing_q[`DLCR_PAROFF_BIT])
      // RULE4: parity code
      err_sig_d = `DLCR_SIG_PARITY;
    else
      err_hit = 1'b0;
  end

  // ----------------------------------------
  // guard time decode
  // ----------------------------------------
  // reserved code 7 falls back to the longest guard
  always @*
  begin
    // RULE13: guard code table
    case (timing_q[`DLCR_GT_MSB:0])
      3'h0: guard_load = `DLCR_GUARD_MAX;
      3'h1: guard_load = `DLCR_GUARD_MAX >> 1;
      3'h2: guard_load = `DLCR_GUARD_MAX >> 2;
      3'h3: guard_load = `DLCR_GUARD_MAX >> 3;
      3'h4: guard_load = `DLCR_GUARD_MAX >> 4;
      3'h5: guard_load = `DLCR_GUARD_MAX >> 5;
      3'h6: guard_load = `DLCR_GUARD_MAX >> 6;
      default: guard_load = `DLCR_GUARD_MAX;
    endcase
  end

  // ----------------------------------------
  // timers
  // ----------------------------------------
  // guard counts link cycles after a receive-to-transmit turn
  dlcr_timer #(.WIDTH(8)) u_guard (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(i_turnaround),
    .i_stop(o_iface_reset),
    .i_tick(1'b1),
    .i_load(guard_load),
    .o_busy(o_guard_busy),
    .o_expire()
  );

  // RULE9: idle gap after each load byte
  dlcr_timer #(.WIDTH(8)) u_gap (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(i_byte_sent && i_ld_multi && timing_q[`DLCR_GAPEN_BIT]),
    .i_stop(o_iface_reset),
    .i_tick(i_bit_tick),
    .i_load(`DLCR_GAP_BITS),
    .o_busy(o_gap_busy),
    .o_expire()
  );

  // RULE11: response watchdog
  dlcr_timer #(.WIDTH(17)) u_timeout (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_start(i_layer_wait && !timing_q[`DLCR_TOOFF_BIT]),
    .i_stop(i_layer_resp || o_iface_reset),
    .i_tick(1'b1),
    .i_load(TIMEOUT_CYC),
    .o_busy(),
    .o_expire(timeout_hit)
  );

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      timing_q <= `DLCR_TIMING_RST;
      feature_q <= FEATURE_RST[4:2];
      clksel_q <= `DLCR_CLKSEL_RST;
      sysctl_q <= `DLCR_SYSCTL_RST;
      sysrst_q <= `DLCR_SYSRST_RST;
    end
    else if (disable_now)
    begin
      // RULE16: wipe link configuration
      timing_q <= `DLCR_TIMING_RST;
      feature_q <= FEATURE_RST[4:2];
      clksel_q <= `DLCR_CLKSEL_RST;
      sysctl_q <= `DLCR_SYSCTL_RST;
    end
    else
    begin
      // bit 6 has no function and stays zero
      if (wr_timing)
        timing_q <= i_reg_wdata & 8'hbf;
      // disable bit is a command, never stored
      if (wr_feature)
        feature_q <= {i_reg_wdata[`DLCR_NACKOFF_BIT:`DLCR_CCDIS_BIT], 1'b0};
      // RULE21: clock select, reserved 0 kept as written
      if (wr_clksel)
        clksel_q <= i_reg_wdata[1:0];
      // done bit only writable with the user-row key active
      if (wr_sysctl)
      begin
        sysctl_q[`DLCR_CLKREQ_BIT] <= i_reg_wdata[`DLCR_CLKREQ_BIT];
        if (keys_q[2])
          sysctl_q[`DLCR_UROWDONE_BIT] <= i_reg_wdata[`DLCR_UROWDONE_BIT];
      end
      // RULE20: reset word stored as written
      if (wr_sysrst)
        sysrst_q <= i_reg_wdata;
    end
  end

  // ----------------------------------------
  // error signature and key flags
  // ----------------------------------------
  // new events win over a read-clear or write-clear
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      err_sig_q <= `DLCR_SIG_NONE;
      keys_q <= `DLCR_KEYS_RST;
    end
    else
    begin
      // RULE3: load on error, clear on read
      if (err_hit)
        err_sig_q <= err_sig_d;
      else if (rd_err || disable_now)
        err_sig_q <= `DLCR_SIG_NONE;
      // RULE17: user-row flag
      if (i_key_urow)
        keys_q[2] <= 1'b1;
      else if (disable_now || (wr_keys && i_reg_wdata[`DLCR_UROW_BIT]))
        keys_q[2] <= 1'b0;
      // RULE18: nvm programming flag
      if (i_key_nvm)
        keys_q[1] <= 1'b1;
      else if (disable_now || i_nvm_started)
        keys_q[1] <= 1'b0;
      // RULE19: erase flag
      if (i_key_erase)
        keys_q[0] <= 1'b1;
      else if (disable_now ||
               (wr_sysrst && i_reg_wdata == `DLCR_RST_ASSERT))
        keys_q[0] <= 1'b0;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @*
  begin
    rdata_d = 8'h00;
    case (i_reg_addr)
      // RULE2: revision nibble
      `DLCR_OFS_REV: rdata_d = {`DLCR_REVISION, 4'h0};
      `DLCR_OFS_ERR: rdata_d = {5'h00, err_sig_q};
      `DLCR_OFS_TIMING: rdata_d = timing_q;
      `DLCR_OFS_FEATURE: rdata_d = {3'h0, feature_q, 2'h0};
      `DLCR_OFS_KEYS: rdata_d = {2'h0, keys_q, 3'h0};
      `DLCR_OFS_SYSRST: rdata_d = sysrst_q;
      `DLCR_OFS_CLKSEL: rdata_d = {6'h00, clksel_q};
      `DLCR_OFS_SYSCTL: rdata_d = {6'h00, sysctl_q};
      `DLCR_OFS_SYSSTAT: rdata_d = i_sys_state;
      `DLCR_OFS_CRCSTAT: rdata_d = {5'h00, i_crc_state};
      // RULE22: reserved and unmapped read zero
      default: rdata_d = 8'h00;
    endcase
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
      o_parity_check_en <= 1'b1;
      o_resp_sig_en <= 1'b1;
      o_contention_det_en <= 1'b1;
      o_link_clk_sel <= `DLCR_CLKSEL_RST;
      o_timeout <= 1'b0;
      o_send_nack <= 1'b0;
      o_sys_reset_req <= 1'b0;
      o_sys_clk_req <= 1'b0;
      o_urow_done <= 1'b0;
      o_iface_reset <= 1'b0;
    end
    else
    begin
      // read data answers one cycle after the strobe
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd)
        o_reg_rdata <= rdata_d;
      // RULE10: parity check enable
      o_parity_check_en <= !timing_q[`DLCR_PAROFF_BIT];
      // RULE12: response signature enable
      o_resp_sig_en <= !timing_q[`DLCR_SIGOFF_BIT];
      // RULE15: contention detect enable
      o_contention_det_en <= !feature_q[1];
      o_link_clk_sel <= clksel_q;
      o_timeout <= timeout_hit;
      // RULE14: nack on reset during load/store
      o_send_nack <= i_sys_reset_seen && i_ldst_busy && !feature_q[2];
      // RULE20: only the assert word holds reset
      o_sys_reset_req <= (sysrst_q == `DLCR_RST_ASSERT);
      // RULE16: clock request dropped on disable
      o_sys_clk_req <= sysctl_q[`DLCR_CLKREQ_BIT] && !disable_now;
      o_urow_done <= sysctl_q[`DLCR_UROWDONE_BIT];
      o_iface_reset <= disable_now;
    end
  end
endmodule // dlcr_regs

// ---- test/dlcr_link_model.sv ----
// link-side model: bit timing and access-layer answers
`timescale 1ns/10ps
module dlcr_link_model (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // bench control
  input wire i_wait,
  input wire [7:0] i_delay,
  // link strobes
  output reg o_bit_tick,
  output reg o_resp
);
  reg [1:0] div_q; // bit time prescaler
  reg [7:0] cnt_q; // answer countdown, zero means idle
  // ------------------------------------------
  // bit tick every fourth cycle, delayed answer
  // ------------------------------------------
  // delay zero never answers, so the slow access layer is testable
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      div_q <= 2'h0;
      cnt_q <= 8'h00;
      o_bit_tick <= 1'b0;
      o_resp <= 1'b0;
    end
    else
    begin
      div_q <= div_q + 2'h1;
      o_bit_tick <= (div_q == 2'h3);
      o_resp <= (cnt_q == 8'h01);
      // new request restarts the wait
      if (i_wait)
        cnt_q <= i_delay;
      else if (cnt_q != 8'h00)
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule // dlcr_link_model

// ---- test/dlcr_regs_sva.sv ----
// port assertions for the debug link register block
`timescale 1ns/10ps
`include "dlcr_map.vh"
module dlcr_regs_sva #(
  parameter [16:0] TIMEOUT_CYC = `DLCR_TIMEOUT_CYC
) (
  // clock and reset
  input wire i_clk,
  input wire i_resetn,
  // register port
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [3:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire [7:0] o_reg_rdata,
  input wire o_reg_rvalid,
  // events and outputs
  input wire i_layer_wait,
  input wire i_turnaround,
  input wire o_parity_check_en,
  input wire o_contention_det_en,
  input wire o_guard_busy,
  input wire o_timeout,
  input wire o_sys_reset_req,
  input wire o_sys_clk_req,
  input wire o_iface_reset
);
  // expiry flop plus output flop: pulse is seen two edges past the count
  localparam int TO_DLY = TIMEOUT_CYC + 2;
  reg [3:0] ra_q; // address of the read in flight
  reg [2:0] gt_q; // guard code as last written
  wire wr_feat = i_reg_wr && i_reg_addr == 4'h3;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ---------------------
  // shadow of read and guard code
  // ---------------------
  always @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ra_q <= 4'h0;
      gt_q <= 3'h0;
    end
    else
    begin
      if (i_reg_rd)
        ra_q <= i_reg_addr;
      if (i_reg_wr && i_reg_addr == 4'h2)
        gt_q <= i_reg_wdata[2:0];
      else if (wr_feat && i_reg_wdata[2])
        gt_q <= 3'h0;
    end
  end
  // ---------------------
  // assertions
  // ---------------------
  chk_read_answer: assert property (
    i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
  chk_revision_field: assert property (
    o_reg_rvalid && ra_q == 4'h0 |-> o_reg_rdata == {`DLCR_REVISION, 4'h0})
    else $error("revision byte wrong");
  chk_error_width: assert property (
    o_reg_rvalid && ra_q == 4'h1 |-> o_reg_rdata[7:3] == 5'h00)
    else $error("error byte upper bits set");
  chk_reserved_zero: assert property (
    o_reg_rvalid && ra_q inside {[4'h4:4'h6], [4'hd:4'hf]}
    |-> o_reg_rdata == 8'h00) else $error("reserved read not zero");
  chk_parity_follow: assert property (
    i_reg_wr && i_reg_addr == 4'h2
    |=> ##1 o_parity_check_en != $past(i_reg_wdata[5], 2))
    else $error("parity enable wrong");
  chk_contention_follow: assert property (
    wr_feat && !i_reg_wdata[2]
    |=> ##1 o_contention_det_en != $past(i_reg_wdata[3], 2))
    else $error("contention enable wrong");
  chk_timeout_delay: assert property (
    o_timeout |-> $past(i_layer_wait, TO_DLY)) else $error("timeout moment");
  chk_guard_two: assert property (
    i_turnaround && gt_q == 3'h6 |=> o_guard_busy [*2] ##1 !o_guard_busy)
    else $error("guard length wrong");
  chk_reset_assert: assert property (
    i_reg_wr && i_reg_addr == 4'h8 && i_reg_wdata == 8'h59
    |-> ##2 o_sys_reset_req) else $error("reset not asserted");
  chk_reset_release: assert property (
    i_reg_wr && i_reg_addr == 4'h8 && i_reg_wdata == 8'h00
    |-> ##2 !o_sys_reset_req) else $error("reset not released");
  chk_disable_clear: assert property (
    wr_feat && i_reg_wdata[2] |=> o_iface_reset && !o_sys_clk_req
    ##1 o_parity_check_en && o_contention_det_en)
    else $error("disable did not clear");
  // main scenarios reached
  cover property (o_timeout);
  cover property (wr_feat && i_reg_wdata[2]);
  cover property (i_turnaround && gt_q == 3'h6);
endmodule // dlcr_regs_sva
bind dlcr_regs dlcr_regs_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_dlcr_regs_sva (
  .i_clk, .i_resetn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
  .o_reg_rdata, .o_reg_rvalid, .i_layer_wait, .i_turnaround,
  .o_parity_check_en, .o_contention_det_en, .o_guard_busy, .o_timeout,
  .o_sys_reset_req, .o_sys_clk_req, .o_iface_reset);

// ---- test/tb.sv ----
// self-checking bench for the debug link register block
`timescale 1ns/10ps
module tb;
  // ---------------------
  // signals
  // ---------------------
  reg i_clk, i_resetn, i_reg_wr, i_reg_rd, i_ld_multi, i_ldst_busy;
  reg [3:0] i_reg_addr;
  reg [7:0] i_reg_wdata, i_sys_state, dly;
  reg [2:0] i_crc_state;
  reg [12:0] ev; // one-cycle event strobes
  wire [7:0] o_reg_rdata;
  wire [1:0] o_link_clk_sel;
  wire o_reg_rvalid, i_bit_tick, i_layer_resp, o_parity_check_en;
  wire o_resp_sig_en, o_contention_det_en, o_guard_busy, o_gap_busy;
  wire o_timeout, o_send_nack, o_sys_reset_req, o_sys_clk_req;
  wire o_urow_done, o_iface_reset;
  integer n_mismatch, n_checks, k, n;
  reg [7:0] d;
  reg s;
  // short time-out keeps the run brief
  dlcr_regs #(.TIMEOUT_CYC(17'h0_0014)) i_dlcr_regs (
    .i_clk, .i_resetn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .o_reg_rdata, .o_reg_rvalid, .i_parity_err(ev[0]),
    .i_frame_err(ev[1]), .i_start_err(ev[2]), .i_bus_err(ev[3]),
    .i_contention(ev[4]), .i_bit_tick, .i_turnaround(ev[5]),
    .i_byte_sent(ev[6]), .i_ld_multi, .i_layer_wait(ev[7]), .i_layer_resp,
    .i_key_urow(ev[8]), .i_key_nvm(ev[9]), .i_key_erase(ev[10]),
    .i_nvm_started(ev[11]), .i_sys_reset_seen(ev[12]), .i_ldst_busy,
    .i_sys_state, .i_crc_state, .o_parity_check_en, .o_resp_sig_en,
    .o_contention_det_en, .o_link_clk_sel, .o_guard_busy, .o_gap_busy,
    .o_timeout, .o_send_nack, .o_sys_reset_req, .o_sys_clk_req,
    .o_urow_done, .o_iface_reset);
  dlcr_link_model i_dlcr_link_model (.i_clk, .i_resetn, .i_wait(ev[7]),
    .i_delay(dly), .o_bit_tick(i_bit_tick), .o_resp(i_layer_resp));
  // ---------------------
  // shared tasks
  // ---------------------
  task test_done;
  begin
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  task check(input string nm, input logic [7:0] seen, input logic [7:0] ex);
  begin
    n_checks = n_checks + 1;
    if (seen !== ex)
    begin
      $display("BAD %s exp %h seen %h", nm, ex, seen);
      n_mismatch = n_mismatch + 1;
    end
  end
  endtask
  task wr(input [3:0] a, input [7:0] v);
  begin
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= v;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  end
  endtask
  // read and compare; answer is due just after the edge that takes the read
  task rchk(input [3:0] a, input [7:0] ex);
  begin
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    check("rvalid", o_reg_rvalid, 1'b1);
    check("rdata", o_reg_rdata, ex);
  end
  endtask
  task pls(input integer b);
  begin
    @(posedge i_clk);
    ev[b] <= 1'b1;
    @(posedge i_clk);
    ev <= 13'h0000;
  end
  endtask
  // watch a one-cycle pulse for c cycles: 0 timeout, 1 nack
  task watch(input integer w, input integer c);
  begin
    s = 1'b0;
    repeat (c)
    begin
      #1;
      if ((w == 0) ? o_timeout : o_send_nack)
        s = 1'b1;
      @(posedge i_clk);
    end
  end
  endtask
  // ---------------------
  // scenarios
  // ---------------------
  task t_reset;
  begin
    check("cfg", {o_parity_check_en, o_resp_sig_en, o_contention_det_en,
      o_link_clk_sel}, 5'h1f);
    wr(4'h0, 8'hff);
    wr(4'h5, 8'hff);
    for (k = 0; k < 16; k = k + 1)
    begin
      d = (k == 0) ? 8'h30 : (k == 9) ? 8'h03 : (k == 11) ? i_sys_state :
        (k == 12) ? {5'h00, i_crc_state} : 8'h00;
      rchk(k[3:0], d);
    end
  end
  endtask
  task t_errors;
  begin
    for (k = 0; k < 5; k = k + 1)
    begin
      pls(k);
      rchk(4'h1, (k < 2) ? k + 1 : (k == 2) ? 4 : k + 3);
      rchk(4'h1, 8'h00);
    end
    wr(4'h2, 8'h20);
    pls(0);
    rchk(4'h1, 8'h00);
    wr(4'h3, 8'h08);
    pls(4);
    rchk(4'h1, 8'h00);
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h00);
  end
  endtask
  task t_timeout;
  begin
    dly <= 8'h00;
    pls(7);
    watch(0, 30);
    check("timeout", s, 1'b1);
    rchk(4'h1, 8'h03);
    dly <= 8'h05;
    pls(7);
    watch(0, 30);
    check("answered", s, 1'b0);
    wr(4'h2, 8'h10);
    dly <= 8'h00;
    pls(7);
    watch(0, 30);
    check("detect off", s, 1'b0);
    wr(4'h2, 8'h00);
  end
  endtask
  task t_guard;
  begin
    for (k = 0; k < 8; k = k + 1)
    begin
      wr(4'h2, k[7:0]);
      pls(5);
      n = 0;
      #1;
      while (o_guard_busy === 1'b1 && n < 200)
      begin
        n = n + 1;
        @(posedge i_clk);
        #1;
      end
      check("guard", n[7:0], (k == 7) ? 8'h80 : 8'h80 >> k);
    end
    wr(4'h2, 8'h80);
    i_ld_multi <= 1'b1;
    pls(6);
    n = 0;
    #1;
    for (k = 0; k < 50 && o_gap_busy === 1'b1; k = k + 1)
    begin
      n = n + i_bit_tick;
      @(posedge i_clk);
      #1;
    end
    check("gap ticks", n[7:0], 8'h02);
    i_ld_multi <= 1'b0;
  end
  endtask
  task t_keys;
  begin
    pls(8);
    rchk(4'h7, 8'h20);
    wr(4'h7, 8'h20);
    rchk(4'h7, 8'h00);
    wr(4'ha, 8'h03);
    // user-row flag is cleared, so the done bit stays low one edge after the write
    @(posedge i_clk);
    #1;
    check("urow done", o_urow_done, 1'b0);
    pls(9);
    rchk(4'h7, 8'h10);
    pls(11);
    rchk(4'h7, 8'h00);
    pls(10);
    rchk(4'h7, 8'h08);
    wr(4'h8, 8'h59);
    @(posedge i_clk);
    #1;
    check("sys reset", o_sys_reset_req, 1'b1);
    rchk(4'h7, 8'h00);
    wr(4'h8, 8'h00);
    @(posedge i_clk);
    #1;
    check("sys run", o_sys_reset_req, 1'b0);
  end
  endtask
  task t_nack;
  begin
    i_ldst_busy <= 1'b1;
    pls(12);
    watch(1, 3);
    check("nack", s, 1'b1);
    wr(4'h3, 8'h10);
    pls(12);
    watch(1, 3);
    check("nack off", s, 1'b0);
    i_ldst_busy <= 1'b0;
  end
  endtask
  task t_disable;
  begin
    wr(4'h2, 8'h28);
    wr(4'h9, 8'h01);
    pls(8);
    wr(4'ha, 8'h03);
    @(posedge i_clk);
    #1;
    check("opts", {o_parity_check_en, o_resp_sig_en, o_link_clk_sel,
      o_urow_done, o_sys_clk_req}, 6'h07);
    wr(4'h3, 8'h04);
    #1;
    check("if reset", {o_iface_reset, o_sys_clk_req}, 2'h2);
    rchk(4'h2, 8'h00);
    rchk(4'h3, 8'h00);
    rchk(4'h9, 8'h03);
    rchk(4'h7, 8'h00);
  end
  endtask
  // ---------------------
  // clock, reset and sequence
  // ---------------------
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial
  begin
    {i_resetn, i_reg_wr, i_reg_rd, i_ld_multi, i_ldst_busy} = 5'h00;
    {i_reg_addr, i_reg_wdata, dly, ev} = 33'h0_0000_0000;
    i_sys_state = 8'h15;
    i_crc_state = 3'h2;
    n_mismatch = 0;
    n_checks = 0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    #1;
    t_reset;
    t_errors;
    t_timeout;
    t_guard;
    t_keys;
    t_nack;
    t_disable;
    test_done;
  end
endmodule // tb
